// >>> aebm_ext_dev.sv
// Purpose: Behavioural external device: 256-byte memory behind a 8/16-bit
//          port that ends bus cycles by acknowledge, fault or silence.
// Assumes: Answers only after the data strobe is seen low.
// Notes:   An undriven data bus shows the inverse of its last value.
`timescale 1ns/1ps

module aebm_ext_dev (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic narrow_i,
  input wire logic [7:0] wait_i,
  input wire logic [1:0] mode_i,
  input wire logic [23:0] addr_i,
  input wire logic size_hi_i,
  input wire logic size_lo_i,
  input wire logic rw_i,
  input wire logic as_n_i,
  input wire logic ds_n_i,
  input wire logic [15:0] wdata_i,
  input wire logic wdata_oe_i,
  output logic [15:0] bus_o,
  output logic ack_wide_n_o,
  output logic ack_narrow_n_o,
  output logic fault_n_o,
  output logic halt_n_o
);
  logic [7:0] mem [256];
  logic [7:0] cnt;
  logic busy;
  logic drv;
  logic [15:0] rd;
  logic [15:0] last;
  logic [7:0] a;
  logic [2:0] rem;

  // Lane placement and wire level
  assign a = addr_i[7:0];
  assign rem = ({size_hi_i, size_lo_i} == 2'h0) ? 3'h4 :
               {1'b0, size_hi_i, size_lo_i};
  assign rd = narrow_i ? {mem[a], mem[a]} :
              {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]};
  assign bus_o = wdata_oe_i ? wdata_i : (drv ? rd : ~last);

  // Cycle length is ours to set; release once the address strobe rises
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      drv <= 1'b0;
      last <= 16'h0000;
      ack_wide_n_o <= 1'b1;
      ack_narrow_n_o <= 1'b1;
      fault_n_o <= 1'b1;
      halt_n_o <= 1'b1;
    end else begin
      last <= bus_o;
      if (as_n_i) begin
        cnt <= 8'h00;
        busy <= 1'b0;
        drv <= 1'b0;
        ack_wide_n_o <= 1'b1;
        ack_narrow_n_o <= 1'b1;
        fault_n_o <= 1'b1;
        halt_n_o <= 1'b1;
      end else if (!busy && !ds_n_i && cnt < wait_i) begin
        cnt <= cnt + 8'h01;
      end else if (!busy && !ds_n_i) begin
        busy <= 1'b1;
        case (mode_i)
          2'h0: begin
            ack_wide_n_o <= narrow_i;
            ack_narrow_n_o <= !narrow_i;
            drv <= rw_i;
            if (!rw_i && !narrow_i && a[0]) begin
              mem[a] <= wdata_i[7:0];
            end else if (!rw_i) begin
              mem[a] <= wdata_i[15:8];
            end
            if (!rw_i && !narrow_i && !a[0] && rem > 3'h1) begin
              mem[a + 8'h01] <= wdata_i[7:0];
            end
          end
          2'h1: fault_n_o <= 1'b0;
          2'h2: begin
            fault_n_o <= 1'b0;
            halt_n_o <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// >>> aebm_master.sv
// Purpose: External bus master; runs asynchronous, acknowledge-ended bus
//          cycles for byte, word, 3-byte and long operands.
// Assumes: Bus timing counted in half bus clocks from a divider enable.
// Notes:   Narrow ports answer on the upper data lane.
`timescale 1ns/1ps

module aebm_master #(
  parameter int HALF_CYC = aebm_pkg::HALF_BUS_CYC,
  parameter int MON_HALVES = aebm_pkg::BUS_MON_HALVES
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_read_i,
  input wire logic [1:0] req_size_i,
  input wire logic [2:0] req_space_i,
  input wire logic [23:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  output logic done_o,
  output logic done_fault_o,
  output logic fault_exc_o,
  output logic [31:0] rdata_o,
  output logic [23:0] addr_o,
  output logic xfer_size_hi_o,
  output logic xfer_size_lo_o,
  output logic [2:0] space_code_o,
  output logic read_not_write_o,
  output logic addr_valid_strobe_n_o,
  output logic data_valid_strobe_n_o,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic ack_port_wide_n_i,
  input wire logic ack_port_narrow_n_i,
  input wire logic bus_fault_n_i,
  input wire logic halt_n_i
);
  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_ASSERT, ST_WDRV, ST_WAIT, ST_LATCH, ST_END
  } aebm_state_type;

  typedef struct packed {
    aebm_state_type st;
    logic [15:0] ph_cnt;
    logic [15:0] mon_cnt;
    logic [2:0] rem;
    logic [23:0] addr;
    logic [2:0] space;
    logic rw;
    logic as_n;
    logic ds_n;
    logic doe;
    logic [15:0] dout;
    logic [31:0] wbuf;
    logic [31:0] rbuf;
    logic two;
    logic lo_lane;
    logic fault;
    logic done;
    logic exc;
    logic [17:0] as_age;
    logic [15:0] st_age;
  } aebm_master_type;

  aebm_master_type s_r;
  aebm_master_type s_nxt;

  logic [19:0] pins_sync;
  logic [15:0] din_s;
  logic ack_wide;
  logic ack_narrow;
  logic fault_in;
  logic halt_in;
  logic ph_en;
  logic mon_out;
  logic [2:0] nbytes;
  logic [7:0] rbyte;

  initial begin
    if (HALF_CYC < 1 || HALF_CYC > 65535) $error("HALF_CYC out of range");
    if (MON_HALVES < 1 || MON_HALVES > 65535) $error("MON_HALVES out of range");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  aebm_sync #(
    .WIDTH(20),
    .RST_VAL(20'hF_0000)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .din_i({ack_port_wide_n_i, ack_port_narrow_n_i, bus_fault_n_i,
            halt_n_i, data_i}),
    .dout_o(pins_sync)
  );

  // Active-high views of the synchronised pins
  assign ack_wide = !pins_sync[19];
  assign ack_narrow = !pins_sync[18];
  assign fault_in = !pins_sync[17];
  assign halt_in = !pins_sync[16];
  assign din_s = pins_sync[15:0];

  // Half bus clock enable and monitor timeout
  assign ph_en = (s_r.ph_cnt == 16'(HALF_CYC - 1));
  assign mon_out = (s_r.mon_cnt >= 16'(MON_HALVES - 1));

  // Bytes moved: two only for a wide port at an even address
  assign nbytes = (ack_wide && !s_r.addr[0] && s_r.rem >= 3'h2) ?
                  3'h2 : 3'h1;
  assign rbyte = s_r.lo_lane ? din_s[7:0] : din_s[15:8];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.exc = 1'b0;
    s_nxt.ph_cnt = ph_en ? 16'h0000 : s_r.ph_cnt + 16'h0001;
    // Helper ages for the timing checks: strobe low, time in start
    s_nxt.as_age = s_r.as_n ? 18'h0_0000 :
                   s_r.as_age + {17'h0_0000, ~&s_r.as_age};
    s_nxt.st_age = (s_r.st != ST_START) ? 16'h0000 :
                   s_r.st_age + {15'h0000, ~&s_r.st_age};
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.ph_cnt = 16'h0000;
        if (req_valid_i) begin
          s_nxt.st = ST_START;
          s_nxt.addr = req_addr_i;
          s_nxt.space = req_space_i;
          s_nxt.rem = (req_size_i == aebm_pkg::SIZE_LONG) ? 3'h4 :
                      {1'b0, req_size_i};
          s_nxt.fault = 1'b0;
          s_nxt.rbuf = 32'h0000_0000;
          // Left-align the operand so the next byte sits on top
          case (req_size_i)
            aebm_pkg::SIZE_BYTE: s_nxt.wbuf = {req_wdata_i[7:0], 24'h00_0000};
            aebm_pkg::SIZE_WORD: s_nxt.wbuf = {req_wdata_i[15:0], 16'h0000};
            aebm_pkg::SIZE_3BYTE: s_nxt.wbuf = {req_wdata_i[23:0], 8'h00};
            default: s_nxt.wbuf = req_wdata_i;
          endcase
          s_nxt.rw = req_read_i;
        end
      end
      ST_START: begin
        // Address, size, space and direction already stand
        s_nxt.doe = 1'b0;
        if (ph_en) begin
          s_nxt.st = s_r.rw ? ST_WAIT : ST_ASSERT;
          s_nxt.as_n = 1'b0;
          s_nxt.ds_n = !s_r.rw;
          s_nxt.mon_cnt = 16'h0000;
        end
      end
      ST_ASSERT: begin
        if (ph_en) begin
          s_nxt.st = ST_WDRV;
          s_nxt.doe = 1'b1;
          s_nxt.dout = s_r.addr[0] ? {s_r.wbuf[31:24], s_r.wbuf[31:24]} :
                       s_r.wbuf[31:16];
        end
      end
      ST_WDRV: begin
        if (ph_en) begin
          s_nxt.st = ST_WAIT;
          s_nxt.ds_n = 1'b0;
        end
      end
      ST_WAIT: begin
        // Length of the cycle belongs to the responder
        if (ph_en) begin
          s_nxt.mon_cnt = s_r.mon_cnt + 16'h0001;
          if (fault_in || mon_out) begin
            s_nxt.st = ST_END;
            s_nxt.fault = 1'b1;
            s_nxt.exc = fault_in && halt_in;
            s_nxt.as_n = 1'b1;
            s_nxt.ds_n = 1'b1;
          end else if (ack_wide || ack_narrow) begin
            s_nxt.two = (nbytes == 3'h2);
            s_nxt.lo_lane = ack_wide && s_r.addr[0];
            if (s_r.rw) begin
              s_nxt.st = ST_LATCH;
            end else begin
              // Address and size move only once the strobes are negated
              s_nxt.rem = s_r.rem - nbytes;
              s_nxt.addr = s_r.addr + {21'h00_0000, nbytes};
              s_nxt.wbuf = (nbytes == 3'h2) ? {s_r.wbuf[15:0], 16'h0000} :
                           {s_r.wbuf[23:0], 8'h00};
              s_nxt.st = ST_END;
              s_nxt.as_n = 1'b1;
              s_nxt.ds_n = 1'b1;
            end
          end
        end
      end
      ST_LATCH: begin
        // Capture on the cycle's last edge and release strobes on that same edge
        if (ph_en) begin
          s_nxt.rbuf = s_r.two ? {s_r.rbuf[15:0], din_s} :
                       {s_r.rbuf[23:0], rbyte};
          s_nxt.rem = s_r.rem - (s_r.two ? 3'h2 : 3'h1);
          s_nxt.addr = s_r.addr + (s_r.two ? 24'h00_0002 : 24'h00_0001);
          s_nxt.st = ST_END;
          s_nxt.as_n = 1'b1;
          s_nxt.ds_n = 1'b1;
        end
      end
      ST_END: begin
        // Wait for acks and fault to clear so none ends the next cycle
        if (ph_en && !ack_wide && !ack_narrow && !fault_in) begin
          s_nxt.doe = 1'b0;
          if (s_r.fault || s_r.rem == 3'h0) begin
            s_nxt.st = ST_IDLE;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = ST_START;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '{st: ST_IDLE, ph_cnt: 16'h0000, mon_cnt: 16'h0000,
               rem: 3'h0, addr: aebm_pkg::ADDR_RST, space: 3'h0,
               rw: 1'b1, as_n: 1'b1, ds_n: 1'b1, doe: 1'b0,
               dout: aebm_pkg::DATA_RST, wbuf: 32'h0000_0000,
               rbuf: 32'h0000_0000, two: 1'b0, lo_lane: 1'b0,
               fault: 1'b0, done: 1'b0, exc: 1'b0,
               as_age: 18'h0_0000, st_age: 16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign req_ready_o = (s_r.st == ST_IDLE);
  assign done_o = s_r.done;
  assign done_fault_o = s_r.done && s_r.fault;
  assign fault_exc_o = s_r.exc;
  assign rdata_o = s_r.rbuf;
  assign addr_o = s_r.addr;
  assign xfer_size_hi_o = s_r.rem[1];
  assign xfer_size_lo_o = s_r.rem[0];
  assign space_code_o = s_r.space;
  assign read_not_write_o = s_r.rw;
  assign addr_valid_strobe_n_o = s_r.as_n;
  assign data_valid_strobe_n_o = s_r.ds_n;
  assign data_o = s_r.dout;
  assign data_oe_o = s_r.doe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_addr_held_strobe: assert property (
    !addr_valid_strobe_n_o && $past(!addr_valid_strobe_n_o) |->
    $stable(addr_o)) else $error("address moved under strobe");
  a_size_held_strobe: assert property (
    !addr_valid_strobe_n_o && $past(!addr_valid_strobe_n_o) |->
    $stable({xfer_size_hi_o, xfer_size_lo_o}))
    else $error("size moved under strobe");
  a_space_held: assert property (
    !addr_valid_strobe_n_o && $past(!addr_valid_strobe_n_o) |->
    $stable(space_code_o)) else $error("space moved under strobe");
  a_rw_at_start: assert property (
    $changed(read_not_write_o) |-> s_r.st == ST_START)
    else $error("direction changed outside cycle start");
  a_read_ds_with_as: assert property (
    $fell(addr_valid_strobe_n_o) && read_not_write_o |->
    $fell(data_valid_strobe_n_o)) else $error("read strobes apart");
  a_write_ds_late: assert property (
    !addr_valid_strobe_n_o && !read_not_write_o &&
    s_r.as_age <= 18'(2 * HALF_CYC) |->
    data_valid_strobe_n_o == (s_r.as_age < 18'(2 * HALF_CYC)))
    else $error("write data strobe not one clock late");
  a_wdata_half: assert property (
    !addr_valid_strobe_n_o && !read_not_write_o &&
    s_r.as_age <= 18'(HALF_CYC) |->
    data_oe_o == (s_r.as_age == 18'(HALF_CYC)))
    else $error("write data not half clock late");
  a_as_half: assert property (
    $fell(addr_valid_strobe_n_o) |->
    $past(s_r.st == ST_START && s_r.st_age == 16'(HALF_CYC - 1)))
    else $error("address strobe not half clock late");
  a_data_held_end: assert property (
    $rose(addr_valid_strobe_n_o) && !read_not_write_o |-> data_oe_o)
    else $error("write data dropped before strobes");
  a_fault_exc: assert property (
    fault_exc_o |-> s_r.fault && addr_valid_strobe_n_o)
    else $error("exception without fault end");

  c_read_done: cover property (done_o && read_not_write_o && !s_r.fault);
  c_write_done: cover property (done_o && !read_not_write_o);
  c_fault_end: cover property (done_fault_o);
  c_narrow_long: cover property (s_r.st == ST_START && s_r.rem == 3'h3);
endmodule

// >>> aebm_sync.sv
// Purpose: Shared constants of the external bus master, and a 3-stage
//          input synchroniser for pins that arrive from outside.
// Assumes: One system clock at 50 MHz, asynchronous active-low reset.
// Notes:   The synchroniser's output moves only when stages two and three
//          agree, so a single-stage glitch never reaches the bus logic.

// ----------------------------------------------------------------------
// Shared constants
// ----------------------------------------------------------------------
package aebm_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int HALF_BUS_NS = 20;
  // Sys clocks per half bus clock; at least one
  localparam int HALF_BUS_CYC = (HALF_BUS_NS / CLK_PERIOD_NS) < 1 ?
                                1 : (HALF_BUS_NS / CLK_PERIOD_NS);
  localparam int BUS_MON_HALVES = 64;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  // Remaining-size codes
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_3BYTE = 2'h3;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  // Space codes
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
  localparam logic [2:0] SPACE_CONTROL = 3'h7;
  // Reset values of the pin outputs
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Three-flop synchroniser with agreement filter
// ----------------------------------------------------------------------
module aebm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] dout_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } aebm_sync_type;

  aebm_sync_type st_r;
  aebm_sync_type st_nxt;

  initial begin
    if (WIDTH < 1) $error("aebm_sync: WIDTH must be at least 1");
  end

  // Shift chain; a bit moves on only when stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout_o = st_r.q;
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench of the external bus master.
// Assumes: One bus clock half per system clock, short bus monitor.
// Notes:   Each scenario task drives operands and judges the result.
`timescale 1ns/1ps

module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic [1:0] req_size = 2'h0;
  logic [2:0] req_space = 3'h1;
  logic [23:0] req_addr = 24'h00_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic narrow = 1'b0;
  logic [7:0] wait_c = 8'h00;
  logic [1:0] mode = 2'h0;
  logic req_ready, done, done_fault, fault_exc, rw, as_n, ds_n, oe;
  logic size_hi, size_lo, ack_w_n, ack_n_n, fault_n, halt_n;
  logic [31:0] rdata;
  logic [23:0] addr;
  logic [2:0] space;
  logic [15:0] dout, bus;
  int n_mismatch = 0;
  int checked = 0;

  // --------------------------------------------------------------------
  // Clock, design and far side
  // --------------------------------------------------------------------
  always #10 sys_clk_i = ~sys_clk_i;

  aebm_master #(.HALF_CYC(1), .MON_HALVES(48)) u_aebm_master (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_read_i(req_read), .req_size_i(req_size),
    .req_space_i(req_space), .req_addr_i(req_addr),
    .req_wdata_i(req_wdata), .done_o(done), .done_fault_o(done_fault),
    .fault_exc_o(fault_exc), .rdata_o(rdata), .addr_o(addr),
    .xfer_size_hi_o(size_hi), .xfer_size_lo_o(size_lo),
    .space_code_o(space), .read_not_write_o(rw),
    .addr_valid_strobe_n_o(as_n), .data_valid_strobe_n_o(ds_n),
    .data_i(bus), .data_o(dout), .data_oe_o(oe),
    .ack_port_wide_n_i(ack_w_n), .ack_port_narrow_n_i(ack_n_n),
    .bus_fault_n_i(fault_n), .halt_n_i(halt_n));

  aebm_ext_dev u_aebm_ext_dev (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .narrow_i(narrow),
    .wait_i(wait_c), .mode_i(mode), .addr_i(addr), .size_hi_i(size_hi),
    .size_lo_i(size_lo), .rw_i(rw), .as_n_i(as_n), .ds_n_i(ds_n),
    .wdata_i(dout), .wdata_oe_i(oe), .bus_o(bus), .ack_wide_n_o(ack_w_n),
    .ack_narrow_n_o(ack_n_n), .fault_n_o(fault_n), .halt_n_o(halt_n));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge sys_clk_i);
    #1;
  endtask

  // Runs one operand, checks the first bus cycle, waits for done
  task automatic do_op(input logic rd, input logic [1:0] sz,
                       input logic [2:0] sp, input logic [23:0] ad,
                       input logic [31:0] wd, output logic [31:0] rdv,
                       output logic flt, output logic exc, output int lat);
    int i;
    i = 0;
    lat = 0;
    while (req_ready !== 1'b1 && i < 50) begin
      tick();
      i++;
    end
    if (req_ready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    req_valid = 1'b1;
    req_read = rd;
    req_size = sz;
    req_space = sp;
    req_addr = ad;
    req_wdata = wd;
    tick();
    req_valid = 1'b0;
    while (as_n !== 1'b0 && i < 100) begin
      tick();
      i++;
    end
    if (as_n !== 1'b0) begin
      n_mismatch++;
      complete_run();
    end
    chk_v(32'(addr), 32'(ad));
    chk_v(32'({size_hi, size_lo}), 32'(sz));
    chk_v(32'(space), 32'(sp));
    chk_v(32'(rw), 32'(rd));
    if (rd) begin
      chk_v(32'(ds_n), 32'h0);
    end else begin
      chk_v(32'({ds_n, oe}), 32'h2);
      tick();
      chk_v(32'({ds_n, oe}), 32'h3);
      tick();
      chk_v(32'({ds_n, oe}), 32'h1);
    end
    exc = fault_exc;
    i = 0;
    while (done !== 1'b1 && i < 1000) begin
      tick();
      i++;
      lat++;
      exc = exc | fault_exc;
    end
    if (i >= 1000) begin
      n_mismatch++;
      complete_run();
    end
    rdv = rdata;
    flt = done_fault;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Every size on both port widths, odd and even addresses, all spaces
  task automatic t_sizes;
    logic [2:0] sp_tab [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    logic [31:0] rv, wd, mask;
    logic f, e;
    int lat, nb, k;
    k = 0;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        narrow = p[0];
        nb = (s == 0) ? 4 : s;
        mask = (nb == 4) ? 32'hFFFF_FFFF : ((32'h1 << (8 * nb)) - 32'h1);
        wd = 32'hA1B2_C3D4 + 32'(k);
        do_op(1'b0, s[1:0], sp_tab[k % 5], 24'(8'h10 + 32 * p + 8 * s + s % 2),
              wd, rv, f, e, lat);
        chk_v(32'(f), 32'h0);
        k++;
        do_op(1'b1, s[1:0], sp_tab[k % 5], 24'(8'h10 + 32 * p + 8 * s + s % 2),
              32'h0, rv, f, e, lat);
        chk_v(rv, wd & mask);
        k++;
      end
    end
  endtask

  // A slow device stretches the cycle
  task automatic t_slow;
    logic [31:0] rv;
    logic f, e;
    int lat;
    narrow = 1'b0;
    wait_c = 8'h14;
    do_op(1'b0, 2'h2, 3'h5, 24'h00_0080, 32'h0000_5A3C, rv, f, e, lat);
    chk_v(32'(lat >= 20), 32'h1);
    do_op(1'b1, 2'h2, 3'h5, 24'h00_0080, 32'h0, rv, f, e, lat);
    chk_v(rv, 32'h0000_5A3C);
    wait_c = 8'h00;
  endtask

  // Fault alone, fault with halt, and a silent device
  task automatic t_fault;
    logic [31:0] rv;
    logic f, e;
    int lat;
    for (int m = 1; m < 4; m++) begin
      mode = m[1:0];
      do_op(1'b1, 2'h0, 3'h1, 24'h00_0040, 32'h0, rv, f, e, lat);
      chk_v(32'(f), 32'h1);
      chk_v(32'(e), 32'(m == 2));
    end
    mode = 2'h0;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_v(32'({req_ready, as_n, ds_n, oe}), 32'hE);
    rst_b_i = 1'b1;
    t_sizes();
    t_slow();
    t_fault();
    complete_run();
  end
endmodule
